//--- logic/mulc_regs.vh
// Behaviour
// - low hold then rising edge enters communication mode, starts 300 us timeout.
// - code timeout stops at first sync bit of an incoming frame.
// - wrong code, abort or bad transaction returns to output mode; retry allowed.
// - correct code with lowest bit set after pulse entry sets hold bit, disables output, stays unlocked.
// - analog mode opens 40 ms window after reset and shadow load; expiry locks.
// - analog mode locks after three failed unlock attempts until next reset.
// - second sync pauses window; wrong code or abort resumes it, counts failure.
// - overvoltage and guard: unlock value first, then 1 ms for code with hold set.
// - no overvoltage, guard set: unlock value, then 1 ms for either access code.
// - no overvoltage, guard clear: access code accepted directly in 40 ms window.
// - correct analog-mode access code keeps device unlocked until next reset.
// - access code is 31 fixed upper bits; its lowest bit loads the hold bit.
// - hold bit disables output; clears on reset or a write of zero.
// - codes are 32-bit writes to 0x86; access codes c2d8e67b and c2d8e67a.
// - customer access allows factory reads but blocks factory writes.
// - frame ends in 3-bit CRC over non-sync bits, initialised to 111.
// - Manchester one is a falling mid-bit edge, zero a rising one.
// - frame is 2 sync, rw, 2 cs, 8 address, 32 data on writes, 3 CRC.
`ifndef MULC_REGS_VH
`define MULC_REGS_VH
`define MULC_ACCESS_ADDR 8'h86
`define MULC_CODE_HI 31'h616c733d
`define MULC_CRC_INIT 3'h7
`define MULC_CRC_POLY 3'h3
`define MULC_MODE_ANALOG 2'h0
`define MULC_MODE_PWM 2'h1
`define MULC_MODE_SENT 2'h2
`define MULC_SENT_HOLD_TICKS 8'h1e
`define MULC_MAX_FAILS 2'h3
// timing counts at 25 mhz: 300 us, 40 ms, 1 ms
`define MULC_T_CODE_CYC 24'h001d4c
`define MULC_T_WIN_CYC 24'h0f4240
`define MULC_T_STAGE_CYC 24'h0061a8
`define MULC_RD_BITS 6'h0e
`define MULC_WR_BITS 6'h2e
`endif

//--- logic/mulc_unlock.v
`timescale 1ns/1ps
`include "mulc_regs.vh"
module mulc_unlock #(
   parameter [23:0] CODE_CYC = `MULC_T_CODE_CYC,
   parameter [23:0] WIN_CYC = `MULC_T_WIN_CYC,
   parameter [23:0] STAGE_CYC = `MULC_T_STAGE_CYC,
   parameter [2:0] CRC_POLY = `MULC_CRC_POLY,
   // arbitrary neutral value for the fixed unlock word
   parameter [31:0] UNLOCK_VAL = 32'h5a5a0f0f
) (
   input wire CLK_SYS,
   input wire RESET_N,
   input wire LINE_IN,
   input wire OVERVOLTAGE_ENTRY,
   input wire [1:0] OUTPUT_MODE,
   input wire ANALOG_SERIAL_GUARD,
   input wire OVERVOLTAGE_REQUIRED,
   input wire SHADOW_LOADED,
   input wire [23:0] PWM_PERIOD_CYC,
   input wire [15:0] SENT_TICK_CYC,
   output wire OUTPUT_DISABLE,
   output wire COMM_ACTIVE,
   output wire UNLOCKED,
   output wire SERIAL_HOLD,
   output wire FACTORY_WR_BLOCK,
   output wire ACCESS_LOCKED_OUT,
   output wire [1:0] FAIL_COUNT,
   output reg FRAME_WR_STB,
   output reg FRAME_RD_STB,
   output reg FRAME_CRC_ERR,
   output reg [1:0] FRAME_CS,
   output reg [7:0] FRAME_ADDR,
   output reg [31:0] FRAME_DATA
);
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_MEAS = 4'h2;
   localparam [3:0] S_SAMP = 4'h4;
   localparam [3:0] S_EDGE = 4'h8;

   function [2:0] crc_step;
      input [2:0] c;
      input b;
      begin
         crc_step = {c[1:0], 1'b0} ^ ((c[2] ^ b) ? CRC_POLY : 3'h0);
      end
   endfunction

   reg [1:0] ln_sync_r;
   reg [1:0] ov_sync_r;
   reg ln_prev_r;
   wire ln = ln_sync_r[1];
   wire ov = ov_sync_r[1];
   wire fall = ln_prev_r & ~ln;
   wire rise = ~ln_prev_r & ln;

   reg [3:0] st_r;
   reg [15:0] cnt_r;
   reg [15:0] half_r;
   reg [5:0] bitn_r;
   reg bit_r;
   reg rw_r;
   reg [45:0] sr_r;
   reg [2:0] crc_r;
   reg first_r;
   reg sync2_r;
   reg done_r;
   reg abort_r;

   reg comm_r;
   reg hold_r;
   reg ana_unl_r;
   reg locked_r;
   reg paused_r;
   reg stage_r;
   reg [1:0] fails_r;
   reg tmo_run_r;
   reg [23:0] tmo_r;
   reg [23:0] win_r;
   reg t1_run_r;
   reg [23:0] t1_r;
   reg [25:0] low_r;

   wire pulse_mode = (OUTPUT_MODE != `MULC_MODE_ANALOG);
   wire unl = pulse_mode ? hold_r : ana_unl_r;
   wire win_open = ~pulse_mode & SHADOW_LOADED & ~locked_r;
   wire rx_en = pulse_mode ? (comm_r | hold_r) :
                (ana_unl_r | (win_open & (ov | ~OVERVOLTAGE_REQUIRED)));
   wire [5:0] len = rw_r ? `MULC_RD_BITS : `MULC_WR_BITS;
   wire [16:0] samp_at = {1'b0, half_r} + {2'b00, half_r[15:1]};
   wire [16:0] edge_max = {half_r, 1'b0};
   wire last_bit = (bitn_r != 6'h00) && (bitn_r == len);

   // receiver, only listening while entry is possible or unlocked
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         ln_sync_r <= 2'h3;
         ov_sync_r <= 2'h0;
         ln_prev_r <= 1'b1;
         st_r <= S_IDLE;
         cnt_r <= 16'h0000;
         half_r <= 16'h0000;
         bitn_r <= 6'h00;
         bit_r <= 1'b0;
         rw_r <= 1'b0;
         sr_r <= 46'h0;
         crc_r <= `MULC_CRC_INIT;
         first_r <= 1'b0;
         sync2_r <= 1'b0;
         done_r <= 1'b0;
         abort_r <= 1'b0;
      end else begin
         ln_sync_r <= {ln_sync_r[0], LINE_IN};
         ov_sync_r <= {ov_sync_r[0], OVERVOLTAGE_ENTRY};
         ln_prev_r <= ln;
         first_r <= 1'b0;
         sync2_r <= 1'b0;
         done_r <= 1'b0;
         abort_r <= 1'b0;
         cnt_r <= cnt_r + 16'h0001;
         case (st_r)
            S_IDLE: begin
               if (rx_en && fall) begin
                  st_r <= S_MEAS;
                  cnt_r <= 16'h0000;
                  crc_r <= `MULC_CRC_INIT;
                  first_r <= 1'b1;
               end
            end
            S_MEAS: begin
               if (rise) begin
                  half_r <= cnt_r;
                  cnt_r <= 16'h0000;
                  bitn_r <= 6'h00;
                  st_r <= S_SAMP;
               end else if (cnt_r == 16'hffff) begin
                  st_r <= S_IDLE;
                  abort_r <= 1'b1;
               end
            end
            S_SAMP: begin
               if ({1'b0, cnt_r} == samp_at) begin
                  bit_r <= ln;
                  cnt_r <= 16'h0000;
                  st_r <= S_EDGE;
                  if (bitn_r == 6'h00) begin
                     if (ln) begin
                        st_r <= S_IDLE;
                        abort_r <= 1'b1;
                     end else begin
                        sync2_r <= 1'b1;
                     end
                  end else begin
                     sr_r <= {sr_r[44:0], ln};
                     if (bitn_r == 6'h01)
                        rw_r <= ln;
                     if (bitn_r + 6'h03 <= len)
                        crc_r <= crc_step(crc_r, ln);
                     if (last_bit) begin
                        st_r <= S_IDLE;
                        done_r <= 1'b1;
                     end
                  end
               end
            end
            S_EDGE: begin
               if (ln != bit_r) begin
                  cnt_r <= 16'h0000;
                  bitn_r <= bitn_r + 6'h01;
                  st_r <= S_SAMP;
               end else if ({1'b0, cnt_r} > edge_max) begin
                  st_r <= S_IDLE;
                  abort_r <= 1'b1;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // frame decode
   wire crc_ok = (sr_r[2:0] == crc_r);
   wire is_wr = ~rw_r;
   wire [1:0] f_cs = rw_r ? sr_r[12:11] : sr_r[44:43];
   wire [7:0] f_addr = rw_r ? sr_r[10:3] : sr_r[42:35];
   wire [31:0] f_data = sr_r[34:3];
   wire to_port = crc_ok & is_wr & (f_addr == `MULC_ACCESS_ADDR);
   wire code_ok = to_port & (f_data[31:1] == `MULC_CODE_HI);
   wire unlock_ok = to_port & (f_data == UNLOCK_VAL);
   wire ana_code_ok = code_ok & (f_data[0] | ~OVERVOLTAGE_REQUIRED);
   wire [25:0] hold_need = (OUTPUT_MODE == `MULC_MODE_PWM) ?
      {1'b0, PWM_PERIOD_CYC, 1'b0} :
      ({10'h000, SENT_TICK_CYC} * {18'h00000, `MULC_SENT_HOLD_TICKS});
   wire ana_fail = ~pulse_mode & paused_r & ~ana_unl_r &
      ((done_r & ~(ANALOG_SERIAL_GUARD & ~stage_r ? unlock_ok :
                   ana_code_ok)) | abort_r);
   wire t1_fail = t1_run_r & (t1_r == STAGE_CYC);
   wire any_fail = ana_fail | (~paused_r & t1_fail);

   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         comm_r <= 1'b0;
         hold_r <= 1'b0;
         ana_unl_r <= 1'b0;
         locked_r <= 1'b0;
         paused_r <= 1'b0;
         stage_r <= 1'b0;
         fails_r <= 2'h0;
         tmo_run_r <= 1'b0;
         tmo_r <= 24'h000000;
         win_r <= 24'h000000;
         t1_run_r <= 1'b0;
         t1_r <= 24'h000000;
         low_r <= 26'h0000000;
      end else begin
         // pulse-triggered entry
         if (ln || !pulse_mode || comm_r || hold_r)
            low_r <= 26'h0000000;
         else if (low_r != 26'h3ffffff)
            low_r <= low_r + 26'h0000001;
         if (pulse_mode && !comm_r && !hold_r && rise &&
             low_r >= hold_need) begin
            comm_r <= 1'b1;
            tmo_run_r <= 1'b1;
            tmo_r <= 24'h000000;
         end
         if (tmo_run_r) begin
            tmo_r <= tmo_r + 24'h000001;
            if (first_r) begin
               tmo_run_r <= 1'b0;
            end else if (tmo_r == CODE_CYC) begin
               tmo_run_r <= 1'b0;
               comm_r <= 1'b0;
            end
         end
         if (pulse_mode && comm_r && (done_r || abort_r)) begin
            comm_r <= 1'b0;
            if (done_r && code_ok)
               hold_r <= f_data[0];
         end
         if (done_r && unl && code_ok)
            hold_r <= f_data[0];
         if (!pulse_mode && !ana_unl_r) begin
            if (win_open && !paused_r) begin
               win_r <= win_r + 24'h000001;
               if (win_r == WIN_CYC)
                  locked_r <= 1'b1;
            end
            if (sync2_r) begin
               paused_r <= 1'b1;
               t1_run_r <= 1'b0;
            end
            if (t1_run_r)
               t1_r <= t1_r + 24'h000001;
            if (done_r || abort_r)
               paused_r <= 1'b0;
            if (done_r && paused_r && !ana_fail) begin
               if (ANALOG_SERIAL_GUARD && !stage_r) begin
                  stage_r <= 1'b1;
                  t1_run_r <= 1'b1;
                  t1_r <= 24'h000000;
               end else begin
                  ana_unl_r <= 1'b1;
                  hold_r <= f_data[0];
               end
            end
            if (any_fail) begin
               stage_r <= 1'b0;
               t1_run_r <= 1'b0;
               fails_r <= fails_r + 2'h1;
               if (fails_r == `MULC_MAX_FAILS - 2'h1)
                  locked_r <= 1'b1;
            end
         end
      end
   end

   // forwarded register traffic once unlocked
   always @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         FRAME_WR_STB <= 1'b0;
         FRAME_RD_STB <= 1'b0;
         FRAME_CRC_ERR <= 1'b0;
         FRAME_CS <= 2'h0;
         FRAME_ADDR <= 8'h00;
         FRAME_DATA <= 32'h00000000;
      end else begin
         FRAME_WR_STB <= done_r & unl & crc_ok & is_wr & ~to_port;
         FRAME_RD_STB <= done_r & unl & crc_ok & rw_r;
         FRAME_CRC_ERR <= done_r & ~crc_ok;
         if (done_r) begin
            FRAME_CS <= f_cs;
            FRAME_ADDR <= f_addr;
            FRAME_DATA <= rw_r ? 32'h00000000 : f_data;
         end
      end
   end

   assign OUTPUT_DISABLE = hold_r | comm_r;
   assign COMM_ACTIVE = comm_r;
   assign UNLOCKED = unl;
   assign SERIAL_HOLD = hold_r;
   assign FACTORY_WR_BLOCK = unl;
   assign ACCESS_LOCKED_OUT = locked_r;
   assign FAIL_COUNT = fails_r;
endmodule // mulc_unlock

//--- verification/mulc_unlock_properties.sv
`timescale 1ns/1ps
module mulc_unlock_properties (
   input wire CLK_SYS,
   input wire RESET_N,
   input wire [1:0] OUTPUT_MODE,
   input wire OUTPUT_DISABLE,
   input wire COMM_ACTIVE,
   input wire UNLOCKED,
   input wire SERIAL_HOLD,
   input wire FACTORY_WR_BLOCK,
   input wire ACCESS_LOCKED_OUT,
   input wire [1:0] FAIL_COUNT,
   input wire FRAME_WR_STB,
   input wire FRAME_RD_STB,
   input wire [7:0] FRAME_ADDR
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   chk_hold_disables: assert property (SERIAL_HOLD |-> OUTPUT_DISABLE)
      else $error("hold bit set with output enabled");
   chk_comm_disables: assert property (COMM_ACTIVE |-> OUTPUT_DISABLE)
      else $error("comm mode with output enabled");
   chk_block_follows: assert property (FACTORY_WR_BLOCK == UNLOCKED)
      else $error("write block differs from unlock");
   chk_wr_one_cycle: assert property (FRAME_WR_STB |=> !FRAME_WR_STB)
      else $error("write strobe longer than one cycle");
   chk_rd_wr_apart: assert property (!(FRAME_WR_STB && FRAME_RD_STB))
      else $error("read and write strobe together");
   chk_access_unstrobed: assert property (FRAME_WR_STB |->
      FRAME_ADDR != 8'h86 && UNLOCKED)
      else $error("write strobe on access port or while locked");
   chk_fails_lock: assert property (FAIL_COUNT == 2'h3 |->
      ##[0:2] ACCESS_LOCKED_OUT)
      else $error("third failure did not lock");
   chk_lock_sticky: assert property (ACCESS_LOCKED_OUT |=>
      ACCESS_LOCKED_OUT)
      else $error("lockout released without reset");
   chk_fails_rise: assert property (FAIL_COUNT != 2'h0 |=>
      FAIL_COUNT >= $past(FAIL_COUNT))
      else $error("failure count went down");
   chk_analog_unlock: assert property (OUTPUT_MODE == 2'h0 && UNLOCKED
      |=> UNLOCKED)
      else $error("analog unlock dropped");
   cover property ($rose(SERIAL_HOLD));
   cover property ($rose(ACCESS_LOCKED_OUT));
   cover property (FRAME_RD_STB);
endmodule // mulc_unlock_properties
bind mulc_unlock mulc_unlock_properties chk_u (
   .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .OUTPUT_MODE(OUTPUT_MODE),
   .OUTPUT_DISABLE(OUTPUT_DISABLE), .COMM_ACTIVE(COMM_ACTIVE),
   .UNLOCKED(UNLOCKED), .SERIAL_HOLD(SERIAL_HOLD),
   .FACTORY_WR_BLOCK(FACTORY_WR_BLOCK), .FAIL_COUNT(FAIL_COUNT),
   .ACCESS_LOCKED_OUT(ACCESS_LOCKED_OUT), .FRAME_WR_STB(FRAME_WR_STB),
   .FRAME_RD_STB(FRAME_RD_STB), .FRAME_ADDR(FRAME_ADDR));

//--- verification/mulc_programmer.sv
`timescale 1ns/1ps
module mulc_programmer #(
   parameter H = 4
) (
   input wire clk,
   output reg line,
   output reg ov
);
   initial line = 1'b1;
   initial ov = 1'b0;
   // line pulled low first, overvoltage raised while it stays low
   task ov_enter(input integer n);
      begin
         @(negedge clk);
         line = 1'b0;
         repeat (n) @(negedge clk);
         ov = 1'b1;
         repeat (n) @(negedge clk);
         line = 1'b1;
         repeat (8) @(negedge clk);
      end
   endtask
   task pulse_low(input integer n);
      begin
         @(negedge clk);
         line = 1'b0;
         repeat (n) @(negedge clk);
         line = 1'b1;
         repeat (8) @(negedge clk);
      end
   endtask
   // one is high then low, zero the reverse
   task bit_out(input b);
      begin
         line = b;
         repeat (H) @(negedge clk);
         line = ~b;
         repeat (H) @(negedge clk);
      end
   endtask
   task send(input wr, input [7:0] a, input [31:0] d, input bad);
      reg [42:0] f;
      reg [2:0] c;
      integer i;
      begin
         f = {~wr, 2'b00, a, d};
         c = 3'h7;
         @(negedge clk);
         bit_out(1'b0);
         bit_out(1'b0);
         for (i = 42; i > (wr ? -1 : 31); i = i - 1) begin
            bit_out(f[i]);
            c = {c[1:0], 1'b0} ^ ((c[2] ^ f[i]) ? 3'h3 : 3'h0);
         end
         c = c ^ {2'b00, bad};
         for (i = 2; i >= 0; i = i - 1) bit_out(c[i]);
         line = 1'b1;
         repeat (4 * H) @(negedge clk);
      end
   endtask
endmodule // mulc_programmer

//--- verification/test_manchester_unlock_controller.sv
`timescale 1ns/1ps
module test_manchester_unlock_controller;
   localparam [31:0] unlock_word = 32'h5a5a0f0f; // arbitrary value
   localparam [31:0] code_hold = 32'hc2d8e67b;
   localparam [31:0] code_free = 32'hc2d8e67a;
   reg clk_sys = 1'b0;
   reg reset_n = 1'b0;
   reg [1:0] mode = 2'h1;
   reg guard = 1'b0;
   reg shadow = 1'b0;
   reg ovreq = 1'b0;
   reg [23:0] pwm_cyc = 24'h14;
   reg [15:0] sent_cyc = 16'h2;
   wire ov_pin;
   wire [1:0] fcs;
   wire [31:0] fdata;
   wire line_in, out_dis, comm, unl, hold, wr_blk, lock_out;
   wire wr_stb, rd_stb, crc_err;
   wire [1:0] fails;
   wire [7:0] addr;
   wire [7:0] st = {out_dis, comm, unl, hold, wr_blk, lock_out, fails};
   integer bad_count = 0;
   integer samples_checked = 0;
   integer wr_n = 0, rd_n = 0, crc_n = 0;
   always #20 clk_sys = ~clk_sys;
   always @(negedge clk_sys) begin
      if (wr_stb === 1'b1) wr_n = wr_n + 1;
      if (rd_stb === 1'b1) rd_n = rd_n + 1;
      if (crc_err === 1'b1) crc_n = crc_n + 1;
   end
   mulc_programmer #(.H(4)) prog_u (.clk(clk_sys), .line(line_in),
      .ov(ov_pin));
   mulc_unlock #(.CODE_CYC(24'h32), .WIN_CYC(24'h7d0), .STAGE_CYC(24'hc8),
      .UNLOCK_VAL(unlock_word)) dut_u (
      .CLK_SYS(clk_sys), .RESET_N(reset_n), .LINE_IN(line_in),
      .OVERVOLTAGE_ENTRY(ov_pin), .OUTPUT_MODE(mode),
      .ANALOG_SERIAL_GUARD(guard), .OVERVOLTAGE_REQUIRED(ovreq),
      .SHADOW_LOADED(shadow), .PWM_PERIOD_CYC(pwm_cyc),
      .SENT_TICK_CYC(sent_cyc), .OUTPUT_DISABLE(out_dis), .COMM_ACTIVE(comm),
      .UNLOCKED(unl), .SERIAL_HOLD(hold), .FACTORY_WR_BLOCK(wr_blk),
      .ACCESS_LOCKED_OUT(lock_out), .FAIL_COUNT(fails),
      .FRAME_WR_STB(wr_stb), .FRAME_RD_STB(rd_stb), .FRAME_CRC_ERR(crc_err),
      .FRAME_CS(fcs), .FRAME_ADDR(addr), .FRAME_DATA(fdata));
   task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task do_reset(input [1:0] m, input g);
      begin
         @(negedge clk_sys);
         reset_n = 1'b0;
         mode = m;
         guard = g;
         shadow = 1'b0;
         repeat (16) @(negedge clk_sys);
         reset_n = 1'b1;
         repeat (4) @(negedge clk_sys);
         shadow = 1'b1;
      end
   endtask
   task test_done;
      begin
         if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      #1600000;
      bad_count = bad_count + 1;
      test_done;
   end
   initial begin
      do_reset(2'h1, 1'b0);
      chk("status", 8'h00, st);
      prog_u.pulse_low(36);
      chk("status", 8'h00, st);
      prog_u.pulse_low(44);
      chk("status", 8'hc0, st);
      repeat (60) @(negedge clk_sys);
      chk("status", 8'h00, st);
      prog_u.pulse_low(44);
      prog_u.send(1'b1, 8'h86, code_hold ^ 32'h10, 1'b0);
      chk("status", 8'h00, st);
      prog_u.pulse_low(44);
      prog_u.send(1'b1, 8'h86, code_hold, 1'b0);
      chk("status", 8'hb8, st);
      prog_u.send(1'b1, 8'h10, 32'h12345678, 1'b0);
      chk("data", 32'h12345678, fdata);
      chk("cs", 2'h0, fcs);
      prog_u.send(1'b0, 8'h20, 32'h0, 1'b0);
      prog_u.send(1'b1, 8'h10, 32'h0, 1'b1);
      chk("wr", 1, wr_n);
      chk("rd", 1, rd_n);
      chk("crc", 1, crc_n);
      chk("addr", 8'h10, addr);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      chk("status", 8'h00, st);
      chk("wr", 1, wr_n);
      pwm_cyc = 24'h0a;
      prog_u.pulse_low(24);
      chk("status", 8'hc0, st);
      do_reset(2'h2, 1'b0);
      prog_u.pulse_low(50);
      chk("status", 8'h00, st);
      prog_u.pulse_low(64);
      chk("status", 8'hc0, st);
      do_reset(2'h0, 1'b0);
      repeat (3) prog_u.send(1'b1, 8'h86, 32'h0, 1'b0);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      chk("status", 8'h07, st);
      do_reset(2'h0, 1'b0);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      repeat (2100) @(negedge clk_sys);
      chk("unlocked", 1, unl);
      do_reset(2'h0, 1'b1);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      prog_u.send(1'b1, 8'h86, unlock_word, 1'b0);
      repeat (250) @(negedge clk_sys);
      prog_u.send(1'b1, 8'h86, unlock_word, 1'b0);
      prog_u.send(1'b1, 8'h86, code_hold, 1'b0);
      chk("status", 8'hba, st);
      do_reset(2'h0, 1'b0);
      repeat (2100) @(negedge clk_sys);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      chk("status", 8'h04, st);
      ovreq = 1'b1;
      do_reset(2'h0, 1'b0);
      prog_u.send(1'b1, 8'h86, code_hold, 1'b0);
      chk("status", 8'h00, st);
      prog_u.ov_enter(8);
      prog_u.send(1'b1, 8'h86, code_free, 1'b0);
      chk("status", 8'h01, st);
      prog_u.send(1'b1, 8'h86, code_hold, 1'b0);
      chk("status", 8'hb9, st);
      test_done;
   end
endmodule // test_manchester_unlock_controller
